/* File: verilog/vprc_pkg.sv */
package vprc_pkg;
  // Bus and datapath widths.
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int PIN_W = 22;
  localparam int IRQ_W = 18;
  localparam int CW    = 16;

  // Register offsets; everything below OFS_PCTL except OFS_PCR is the GPIO group.
  localparam logic [AW-1:0] OFS_PCR   = 8'h00;
  localparam logic [AW-1:0] OFS_PIN_FUNCTION_SELECT = 8'h04;
  localparam logic [AW-1:0] OFS_GDIR  = 8'h08;
  localparam logic [AW-1:0] OFS_GOUT  = 8'h0C;
  localparam logic [AW-1:0] OFS_GIN   = 8'h10;
  localparam logic [AW-1:0] OFS_PCTL  = 8'h20;
  localparam logic [AW-1:0] OFS_IE    = 8'h24;
  localparam logic [AW-1:0] OFS_IS    = 8'h28;
  localparam logic [AW-1:0] OFS_CCA   = 8'h30;
  localparam logic [AW-1:0] OFS_CCB   = 8'h34;
  localparam logic [AW-1:0] OFS_DCTL  = 8'h38;

  // Field positions.
  localparam int PCR_EN_B   = 0;
  localparam int DISP_B     = 0;
  localparam int SRST_B     = 14;
  localparam int HALT_B     = 15;
  localparam int VIE_B      = 31;
  localparam int CEN_B      = 0;
  localparam int CBLK_B     = 1;
  localparam int CRST_B     = 2;
  localparam int GPIO_IRQ_B = 17;

  // Channel control values after reset and while in channel reset.
  localparam logic [CW-1:0] CH_RST_VAL   = 16'h0002;
  localparam logic [CW-1:0] CH_INRST_VAL = 16'h0006;

  // Video clock edges before the last one that a soft or channel reset waits for.
  localparam logic [2:0] SRST_LAST  = 3'h3;
  localparam logic [2:0] CHRST_LAST = 3'h3;

  typedef enum logic [3:0] {
    PS_OFF  = 4'h1,
    PS_HALT = 4'h2,
    PS_SRST = 4'h4,
    PS_RUN  = 4'h8
  } vprc_state_t;

  function automatic logic chan_go(input logic [CW-1:0] c);
    return c[CEN_B] & ~c[CBLK_B] & ~c[CRST_B];
  endfunction
endpackage

/* File: verilog/vprc_if.sv */
`timescale 1ns/1ps
interface vprc_chan_if;
  logic                    wr;
  logic [vprc_pkg::CW-1:0] wdata;
  logic                    clk_edge;
  logic [vprc_pkg::CW-1:0] ctl;
  modport host (output wr, wdata, clk_edge, input ctl);
  modport chan (input wr, wdata, clk_edge, output ctl);
endinterface

interface vprc_irq_if;
  logic [vprc_pkg::IRQ_W-1:0] ev;
  logic [vprc_pkg::DW-1:0]    ie;
  logic                       clr_wr;
  logic [vprc_pkg::IRQ_W-1:0] clr_data;
  logic [vprc_pkg::IRQ_W-1:0] status;
  logic                       pulse;
  modport host (output ev, ie, clr_wr, clr_data, input status, pulse);
  modport irq  (input ev, ie, clr_wr, clr_data, output status, pulse);
endinterface

/* File: verilog/vprc_chan.sv */
`timescale 1ns/1ps
module vprc_chan (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Control carrier
  vprc_chan_if.chan c
);
  logic [vprc_pkg::CW-1:0] ctl_reg, ctl_next;
  logic [2:0]              cnt_reg;

  always_comb begin
    ctl_next = ctl_reg;
    if (ctl_reg[vprc_pkg::CRST_B]) begin
      if (c.clk_edge && cnt_reg == vprc_pkg::CHRST_LAST) begin
        ctl_next = vprc_pkg::CH_RST_VAL;
      end
    end else if (c.wr && c.wdata[vprc_pkg::CRST_B]) begin
      ctl_next = vprc_pkg::CH_INRST_VAL;
    end else if (c.wr && ctl_reg[vprc_pkg::CEN_B]) begin
      ctl_next = {ctl_reg[vprc_pkg::CW-1:3], c.wdata[2:0]};
    end else if (c.wr) begin
      ctl_next = c.wdata;
    end
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (reset_i) ctl_reg <= vprc_pkg::CH_RST_VAL;
    else ctl_reg <= ctl_next;
  end

  // The reset needs the channel clock; a stopped clock leaves it pending.
  always_ff @(posedge clk_i) if (ce_i) begin
    if (reset_i || !ctl_reg[vprc_pkg::CRST_B]) cnt_reg <= 3'h0;
    else if (c.clk_edge) cnt_reg <= cnt_reg + 3'h1;
  end

  assign c.ctl = ctl_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  chan_lock_a: assert property ((c.wr && ctl_reg[0] && !ctl_reg[2] && !c.wdata[2])
    |=> ctl_reg[15:3] == $past(ctl_reg[15:3])) else $error("locked channel field changed");
  chan_clear_a: assert property ((ctl_reg[2] && c.clk_edge && cnt_reg == 3'h3)
    |=> ctl_reg == 16'h0002) else $error("channel reset did not self clear");
endmodule

/* File: verilog/vprc_irq.sv */
`timescale 1ns/1ps
module vprc_irq (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Flag carrier
  vprc_irq_if.irq  q
);
  logic [vprc_pkg::IRQ_W-1:0] status_reg, status_next;
  logic                       armed_reg;
  logic                       pulse_reg;
  logic                       active;
  logic                       clr_hit;
  logic                       fire;

  assign clr_hit = q.clr_wr && |(q.clr_data & status_reg);
  assign active  = q.ie[vprc_pkg::VIE_B] && |(status_reg & q.ie[vprc_pkg::IRQ_W-1:0]);
  assign fire    = active && armed_reg;

  // A flag raised in the cycle of its clearing write stays set.
  always_comb begin
    status_next = status_reg;
    if (q.clr_wr) status_next = status_next & ~q.clr_data;
    status_next = status_next | q.ev;
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (reset_i) status_reg <= '0;
    else status_reg <= status_next;
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (reset_i) armed_reg <= 1'h1;
    else if (clr_hit || !active) armed_reg <= 1'h1;
    else if (fire) armed_reg <= 1'h0;
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (reset_i) pulse_reg <= 1'h0;
    else pulse_reg <= fire;
  end

  assign q.status = status_reg;
  assign q.pulse  = pulse_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  sequence s_fire;
    active && armed_reg;
  endsequence

  irq_pulse_a: assert property (s_fire |=> pulse_reg) else $error("armed pending flag gave no pulse");
  irq_single_a: assert property (pulse_reg |=> (!pulse_reg || $past(clr_hit, 2)))
    else $error("pulse repeated without clearing write");
  irq_set_a: assert property ((|q.ev) |=> ((status_reg & $past(q.ev)) == $past(q.ev)))
    else $error("event flag lost");
  irq_mask_a: assert property (!active |=> !pulse_reg) else $error("masked flags raised pulse");
endmodule

/* File: verilog/vprc_top.sv */
`timescale 1ns/1ps
module vprc_top #(
  parameter int CAP_W = 32
) (
  // Clock, reset and enable
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         ce_i,
  input  wire logic                         por_i,
  // Register port
  input  wire logic [vprc_pkg::AW-1:0]      addr_i,
  input  wire logic [vprc_pkg::DW-1:0]      wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [vprc_pkg::DW-1:0]      rdata_o,
  // DMA data access
  input  wire logic                         dma_rd_i,
  input  wire logic                         dma_wr_i,
  input  wire logic [CAP_W-1:0]             dma_wdata_i,
  output logic                              dma_rready_o,
  output logic                              dma_wready_o,
  output logic      [CAP_W-1:0]             dma_rdata_o,
  // Channel datapath
  input  wire logic [CAP_W-1:0]             cap_word_i,
  output logic      [CAP_W-1:0]             disp_word_o,
  output logic                              disp_word_vld_o,
  input  wire logic [vprc_pkg::IRQ_W-2:0]   irq_ev_i,
  input  wire logic [5:0]                   dma_evt_i,
  // DMA requests
  output logic                              luma_dma_req_a_o,
  output logic                              blue_diff_dma_req_a_o,
  output logic                              red_diff_dma_req_a_o,
  output logic                              luma_dma_req_b_o,
  output logic                              blue_diff_dma_req_b_o,
  output logic                              red_diff_dma_req_b_o,
  // Clock gates and channel status
  output logic                              video_clock_one_gate_o,
  output logic                              video_clock_two_gate_o,
  output logic                              system_time_clock_gate_o,
  output logic      [1:0]                   cap_count_en_o,
  output logic      [1:0]                   cap_go_o,
  output logic                              disp_count_en_o,
  output logic                              disp_go_o,
  output logic      [2:0]                   fifo_flush_o,
  output logic                              irq_o,
  // Video pins
  input  wire logic                         video_clock_one_i,
  input  wire logic                         channel_input_clock_b_i,
  input  wire logic [vprc_pkg::PIN_W-1:0]   vid_out_i,
  input  wire logic [vprc_pkg::PIN_W-1:0]   pin_i,
  output logic      [vprc_pkg::PIN_W-1:0]   pin_o,
  output logic      [vprc_pkg::PIN_W-1:0]   pin_oe_n_o
);
  localparam int PW = vprc_pkg::PIN_W;

  logic                        por_s1_reg, por_s2_reg;
  logic [1:0]                  ck_s1_reg, ck_s2_reg, ck_s3_reg;
  logic [PW-1:0]               pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [1:0]                  ck_rise;
  logic                        rst_s, port_rst, live, acc_ok, wr_ok, gpio_ev, go_a, go_b;
  vprc_pkg::vprc_state_t       state_reg, state_next;
  logic                        pcr_en_reg, halt_reg, srst_reg, disp_reg;
  logic [2:0]                  srst_cnt_reg;
  logic [PW-1:0]               pin_function_select_reg, gdir_reg, gout_reg, drive;
  logic [PW-1:0]               pin_reg, oe_n_reg;
  logic [vprc_pkg::DW-1:0]     ie_reg, rdata_reg, rd_next;
  logic [5:0]                  req_reg;
  logic [CAP_W-1:0]            dma_rdata_reg, disp_word_reg;
  logic                        disp_vld_reg;

  vprc_chan_if cha_if();
  vprc_chan_if chb_if();
  vprc_chan_if dsp_if();
  vprc_irq_if  irq_if();

  // Pins and channel clocks come from outside this clock's domain.
  always_ff @(posedge clk_i) if (ce_i) begin
    por_s1_reg <= por_i;
    por_s2_reg <= por_s1_reg;
    ck_s1_reg  <= {channel_input_clock_b_i, video_clock_one_i};
    ck_s2_reg  <= ck_s1_reg;
    ck_s3_reg  <= ck_s2_reg;
    pin_s1_reg <= pin_i;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
  end

  assign rst_s    = reset_i | por_s2_reg;
  assign port_rst = rst_s | (state_reg == vprc_pkg::PS_SRST);
  assign ck_rise  = ck_s2_reg & ~ck_s3_reg;
  assign live     = state_reg == vprc_pkg::PS_RUN;
  assign acc_ok   = (addr_i < vprc_pkg::OFS_PCTL) | pcr_en_reg;
  assign wr_ok    = wr_i & acc_ok;
  assign gpio_ev  = |((pin_s2_reg ^ pin_s3_reg) & pin_function_select_reg & ~gdir_reg);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      vprc_pkg::PS_OFF: begin
        if (pcr_en_reg) state_next = vprc_pkg::PS_HALT;
      end
      vprc_pkg::PS_HALT: begin
        if (!pcr_en_reg) state_next = vprc_pkg::PS_OFF;
        else if (srst_reg) state_next = vprc_pkg::PS_SRST;
        else if (!halt_reg) state_next = vprc_pkg::PS_RUN;
      end
      vprc_pkg::PS_SRST: begin
        if (ck_rise[0] && srst_cnt_reg == vprc_pkg::SRST_LAST) state_next = vprc_pkg::PS_HALT;
      end
      vprc_pkg::PS_RUN: begin
        if (!pcr_en_reg) state_next = vprc_pkg::PS_OFF;
        else if (srst_reg) state_next = vprc_pkg::PS_SRST;
      end
    endcase
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (rst_s) state_reg <= vprc_pkg::PS_OFF;
    else state_reg <= state_next;
  end

  // Soft reset can only complete while the first video clock toggles.
  always_ff @(posedge clk_i) if (ce_i) begin
    if (state_reg != vprc_pkg::PS_SRST) srst_cnt_reg <= 3'h0;
    else if (ck_rise[0]) srst_cnt_reg <= srst_cnt_reg + 3'h1;
  end

  // The enable bit survives the soft reset on purpose.
  always_ff @(posedge clk_i) if (ce_i) begin
    if (rst_s) pcr_en_reg <= 1'h0;
    else if (wr_i && addr_i == vprc_pkg::OFS_PCR) pcr_en_reg <= wdata_i[vprc_pkg::PCR_EN_B];
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (rst_s) begin
      halt_reg <= 1'h1;
      srst_reg <= 1'h0;
      disp_reg <= 1'h0;
    end else if (state_reg == vprc_pkg::PS_SRST) begin
      halt_reg <= 1'h1;
      disp_reg <= 1'h0;
      srst_reg <= state_next == vprc_pkg::PS_SRST;
    end else if (wr_ok && addr_i == vprc_pkg::OFS_PCTL) begin
      if (wdata_i[vprc_pkg::SRST_B]) srst_reg <= 1'h1;
      if (halt_reg) begin
        halt_reg <= wdata_i[vprc_pkg::HALT_B];
        disp_reg <= wdata_i[vprc_pkg::DISP_B];
      end
    end
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (port_rst) begin
      pin_function_select_reg <= '0;
      gdir_reg  <= '0;
      gout_reg  <= '0;
      ie_reg    <= '0;
    end else if (wr_ok) begin
      if (addr_i == vprc_pkg::OFS_PIN_FUNCTION_SELECT) pin_function_select_reg <= wdata_i[PW-1:0];
      if (addr_i == vprc_pkg::OFS_GDIR) gdir_reg <= wdata_i[PW-1:0];
      if (addr_i == vprc_pkg::OFS_GOUT) gout_reg <= wdata_i[PW-1:0];
      if (addr_i == vprc_pkg::OFS_IE) ie_reg <= wdata_i;
    end
  end

  always_comb begin
    rd_next = '0;
    case (addr_i)
      vprc_pkg::OFS_PCR:   rd_next[vprc_pkg::PCR_EN_B] = pcr_en_reg;
      vprc_pkg::OFS_PIN_FUNCTION_SELECT: rd_next[PW-1:0] = pin_function_select_reg;
      vprc_pkg::OFS_GDIR:  rd_next[PW-1:0] = gdir_reg;
      vprc_pkg::OFS_GOUT:  rd_next[PW-1:0] = gout_reg;
      vprc_pkg::OFS_GIN:   rd_next[PW-1:0] = pin_s2_reg;
      vprc_pkg::OFS_PCTL: begin
        rd_next[vprc_pkg::HALT_B] = halt_reg;
        rd_next[vprc_pkg::SRST_B] = srst_reg;
        rd_next[vprc_pkg::DISP_B] = disp_reg;
      end
      vprc_pkg::OFS_IE:    rd_next = ie_reg;
      vprc_pkg::OFS_IS:    rd_next[vprc_pkg::IRQ_W-1:0] = irq_if.status;
      vprc_pkg::OFS_CCA:   rd_next[vprc_pkg::CW-1:0] = cha_if.ctl;
      vprc_pkg::OFS_CCB:   rd_next[vprc_pkg::CW-1:0] = chb_if.ctl;
      vprc_pkg::OFS_DCTL:  rd_next[vprc_pkg::CW-1:0] = dsp_if.ctl;
      default:             rd_next = '0;
    endcase
    if (!acc_ok) rd_next = '0;
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (rst_s) rdata_reg <= '0;
    else rdata_reg <= rd_i ? rd_next : '0;
  end
  assign rdata_o = rdata_reg;

  assign cha_if.wr       = wr_ok && addr_i == vprc_pkg::OFS_CCA;
  assign chb_if.wr       = wr_ok && addr_i == vprc_pkg::OFS_CCB;
  assign dsp_if.wr       = wr_ok && addr_i == vprc_pkg::OFS_DCTL;
  assign cha_if.wdata    = wdata_i[vprc_pkg::CW-1:0];
  assign chb_if.wdata    = wdata_i[vprc_pkg::CW-1:0];
  assign dsp_if.wdata    = wdata_i[vprc_pkg::CW-1:0];
  assign cha_if.clk_edge = ck_rise[0];
  assign chb_if.clk_edge = ck_rise[1];
  assign dsp_if.clk_edge = ck_rise[0];

  vprc_chan u_cha (.clk_i(clk_i), .reset_i(port_rst), .ce_i(ce_i), .c(cha_if.chan));
  vprc_chan u_chb (.clk_i(clk_i), .reset_i(port_rst), .ce_i(ce_i), .c(chb_if.chan));
  vprc_chan u_dsp (.clk_i(clk_i), .reset_i(port_rst), .ce_i(ce_i), .c(dsp_if.chan));

  assign irq_if.ev       = {gpio_ev, irq_ev_i};
  assign irq_if.ie       = ie_reg;
  assign irq_if.clr_wr   = wr_ok && addr_i == vprc_pkg::OFS_IS;
  assign irq_if.clr_data = wdata_i[vprc_pkg::IRQ_W-1:0];

  vprc_irq u_irq (.clk_i(clk_i), .reset_i(port_rst), .ce_i(ce_i), .q(irq_if.irq));
  assign irq_o = irq_if.pulse;

  // Channel A carries display when display mode is chosen, else capture A.
  assign go_a = disp_reg ? vprc_pkg::chan_go(dsp_if.ctl) : vprc_pkg::chan_go(cha_if.ctl);
  assign go_b = !disp_reg && vprc_pkg::chan_go(chb_if.ctl);

  always_ff @(posedge clk_i) if (ce_i) begin
    if (port_rst) req_reg <= '0;
    else req_reg <= dma_evt_i & {{3{live & go_b}}, {3{live & go_a}}};
  end
  assign luma_dma_req_a_o      = req_reg[0];
  assign blue_diff_dma_req_a_o = req_reg[1];
  assign red_diff_dma_req_a_o  = req_reg[2];
  assign luma_dma_req_b_o      = req_reg[3];
  assign blue_diff_dma_req_b_o = req_reg[4];
  assign red_diff_dma_req_b_o  = req_reg[5];

  // Ready is never withheld, so a stopped port cannot hang the DMA.
  assign dma_rready_o = dma_rd_i;
  assign dma_wready_o = dma_wr_i;

  always_ff @(posedge clk_i) if (ce_i) begin
    if (port_rst) begin
      dma_rdata_reg <= '0;
      disp_word_reg <= '0;
      disp_vld_reg  <= 1'h0;
    end else begin
      dma_rdata_reg <= (dma_rd_i && live && !disp_reg && (go_a || go_b)) ? cap_word_i : '0;
      disp_vld_reg  <= dma_wr_i && live && disp_reg && go_a;
      if (dma_wr_i) disp_word_reg <= dma_wdata_i;
    end
  end
  assign dma_rdata_o     = dma_rdata_reg;
  assign disp_word_o     = disp_word_reg;
  assign disp_word_vld_o = disp_vld_reg;

  assign video_clock_one_gate_o = pcr_en_reg;
  assign video_clock_two_gate_o = pcr_en_reg;
  assign system_time_clock_gate_o = pcr_en_reg;

  assign cap_count_en_o  = {chb_if.ctl[vprc_pkg::CEN_B], cha_if.ctl[vprc_pkg::CEN_B]} & {2{live & !disp_reg}};
  assign cap_go_o        = {go_b, go_a & !disp_reg} & {2{live}};
  assign disp_count_en_o = live & disp_reg & dsp_if.ctl[vprc_pkg::CEN_B];
  assign disp_go_o       = live & disp_reg & go_a;
  assign fifo_flush_o    = {dsp_if.ctl[vprc_pkg::CRST_B], chb_if.ctl[vprc_pkg::CRST_B],
                            cha_if.ctl[vprc_pkg::CRST_B]} | {3{port_rst}};

  // Video pins not selected as GPIO drive only when running with display enabled.
  always_comb begin
    drive            = {PW{live & disp_reg & dsp_if.ctl[vprc_pkg::CEN_B]}};
    drive[PW-1]      = live & disp_reg;
    drive            = (drive & ~pin_function_select_reg) | (pin_function_select_reg & gdir_reg);
  end

  always_ff @(posedge clk_i) if (ce_i) begin
    if (rst_s) begin
      oe_n_reg <= '1;
      pin_reg  <= '0;
    end else begin
      oe_n_reg <= ~drive;
      pin_reg  <= (pin_function_select_reg & gout_reg) | (~pin_function_select_reg & vid_out_i);
    end
  end
  assign pin_o      = pin_reg;
  assign pin_oe_n_o = oe_n_reg | {PW{por_i}};

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  por_hiz_a: assert property (por_i |-> &pin_oe_n_o) else $error("pins driven during power-on reset");
  bus_rst_a: assert property (disable iff (!ce_i) (reset_i && ce_i) |=>
    (!pcr_en_reg && halt_reg && &pin_oe_n_o)) else $error("bus reset left port active");
  dma_idle_a: assert property ((dma_rd_i && !live) |=> dma_rdata_o == '0)
    else $error("stopped port returned live data");
  gpio_only_a: assert property ((rd_i && !pcr_en_reg && addr_i >= 8'h20) |=> rdata_o == '0)
    else $error("port register read while disabled");
  halt_lock_a: assert property ((wr_i && addr_i == 8'h20 && !halt_reg && !wdata_i[14] && !srst_reg && !rst_s)
    |=> $stable(disp_reg) && !halt_reg) else $error("control written after halt cleared");
  srst_keep_a: assert property ((state_reg == vprc_pkg::PS_HALT && srst_reg && pcr_en_reg)
    |=> (state_reg == vprc_pkg::PS_SRST && pcr_en_reg && halt_reg)) else $error("soft reset lost enable");
  req_gate_a: assert property (!live |=> req_reg == '0) else $error("DMA request while stopped");

  // These guard the paths that the bench reaches only indirectly, so a broken gate shows up at once.
  gate_follow_a: assert property ((wr_i && addr_i == vprc_pkg::OFS_PCR && !rst_s)
    |=> video_clock_one_gate_o == $past(wdata_i[vprc_pkg::PCR_EN_B]) && system_time_clock_gate_o == video_clock_one_gate_o)
    else $error("clock gates did not follow enable");
  flush_rst_a: assert property (port_rst |-> &fifo_flush_o)
    else $error("fifo not flushed during reset");
  req_pass_a: assert property ((live && go_a && !port_rst)
    |=> req_reg[2:0] == $past(dma_evt_i[2:0])) else $error("open channel dropped a request");
  pin_hiz_a: assert property (!live |=> &(pin_oe_n_o | $past(pin_function_select_reg)))
    else $error("video pin driven while stopped");
  dma_ready_a: assert property ((dma_rd_i |-> dma_rready_o) and (dma_wr_i |-> dma_wready_o))
    else $error("DMA access not acknowledged");
  srst_done_a: assert property ((state_reg == vprc_pkg::PS_SRST && state_next == vprc_pkg::PS_HALT && !rst_s)
    |=> (!srst_reg && halt_reg && pcr_en_reg)) else $error("soft reset did not finish cleanly");
endmodule

/* File: bench/vprc_dma_model.sv */
`timescale 1ns/1ps
module vprc_dma_model (
  // Clock
  input  wire logic        clk_i,
  // Ready answers from the port
  input  wire logic        rready_i,
  input  wire logic        wready_i,
  // Access strobes and data
  output logic             rd_o,
  output logic             wr_o,
  output logic [31:0]      wdata_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  // The strobe is held until ready is seen at an edge; the cap turns a stall into a visible wait count.
  task automatic access(input logic is_rd, input int slow, output int waited);
    repeat (slow) @(posedge clk_i);
    rd_o <= is_rd;
    wr_o <= ~is_rd;
    wdata_o <= 32'hA5A5_0F0F;
    waited = 0;
    do begin
      @(posedge clk_i);
      waited++;
    end while (!(is_rd ? rready_i : wready_i) && waited < 16);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    wdata_o <= 32'h5A5A_F0F0;
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b0, video_clock_one = 1'b0, vclkb = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, r;
  logic [16:0] ev = 17'h0_0000;
  logic [5:0]  evt = 6'h00;
  wire  [31:0] rdata, dwdata, drdata;
  wire         drd, dwr, rrdy, wrdy, irq, g1, g2, gs;
  wire  [5:0]  req;
  wire  [21:0] oe_n;
  int          mismatches = 0, n_checks = 0, cycles = 0, pulses = 0, w;
  always #5 clk_i = ~clk_i;
  always #23 video_clock_one = ~video_clock_one;
  always #31 vclkb = ~vclkb;
  vprc_top i_vprc_top (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .por_i(por_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .dma_rd_i(drd), .dma_wr_i(dwr),
    .dma_wdata_i(dwdata), .dma_rready_o(rrdy), .dma_wready_o(wrdy), .dma_rdata_o(drdata),
    .cap_word_i(32'h1234_5678), .disp_word_o(), .disp_word_vld_o(), .irq_ev_i(ev), .dma_evt_i(evt),
    .luma_dma_req_a_o(req[0]), .blue_diff_dma_req_a_o(req[1]), .red_diff_dma_req_a_o(req[2]),
    .luma_dma_req_b_o(req[3]), .blue_diff_dma_req_b_o(req[4]), .red_diff_dma_req_b_o(req[5]),
    .video_clock_one_gate_o(g1), .video_clock_two_gate_o(g2), .system_time_clock_gate_o(gs), .cap_count_en_o(), .cap_go_o(),
    .disp_count_en_o(), .disp_go_o(), .fifo_flush_o(), .irq_o(irq), .video_clock_one_i(video_clock_one), .channel_input_clock_b_i(vclkb),
    .vid_out_i(22'h00_0000), .pin_i(22'h15_5555), .pin_o(), .pin_oe_n_o(oe_n));
  vprc_dma_model i_vprc_dma_model (.clk_i(clk_i), .rready_i(rrdy), .wready_i(wrdy), .rd_o(drd), .wr_o(dwr),
    .wdata_o(dwdata));
  always @(posedge clk_i) if (irq === 1'b1) pulses <= pulses + 1;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 r = rdata;
  endtask
  // Counts pulse cycles after a cause, so both a missing and a stretched pulse show up.
  task automatic window(input int exp);
    #1 pulses = 0;
    repeat (6) @(posedge clk_i);
    #1 chk(pulses, exp);
  endtask
  task automatic fire(input int b, input int exp);
    @(posedge clk_i);
    ev <= 17'h0_0001 << b;
    @(posedge clk_i);
    ev <= 17'h0_0000;
    window(exp);
  endtask
  task automatic t_disabled();
    br(8'h20);
    chk(r, 32'h0000_0000);
    chk({g1, g2, gs}, 3'b000);
    bw(8'h24, 32'hFFFF_FFFF);
    bw(8'h04, 32'h0000_0001);
    bw(8'h08, 32'h0000_0001);
    br(8'h04);
    chk(r, 32'h0000_0001);
    #20 chk(oe_n, 22'h3F_FFFE);
  endtask
  task automatic t_enable();
    bw(8'h00, 32'h0000_0001);
    #1 chk({g1, g2, gs}, 3'b111);
    br(8'h20);
    chk(r, 32'h0000_8000);
    br(8'h24);
    chk(r, 32'h0000_0000);
  endtask
  task automatic t_dma();
    i_vprc_dma_model.access(1'b1, 0, w);
    chk(w, 1);
    #1 chk(drdata, 32'h0000_0000);
    i_vprc_dma_model.access(1'b0, 3, w);
    chk(w, 1);
    evt <= 6'h3F;
    repeat (3) @(posedge clk_i);
    chk(req, 6'h00);
    evt <= 6'h00;
  endtask
  task automatic t_irq();
    bw(8'h24, 32'h8000_0003);
    fire(0, 1);
    fire(1, 0);
    br(8'h28);
    chk(r, 32'h0000_0003);
    bw(8'h28, 32'h0000_0001);
    window(1);
    bw(8'h28, 32'h0000_0002);
    window(0);
    bw(8'h24, 32'h0000_0001);
    fire(0, 0);
    bw(8'h28, 32'h0003_FFFF);
  endtask
  task automatic t_soft();
    bw(8'h20, 32'h0000_C000);
    r = 32'h0000_4000;
    for (int i = 0; i < 60 && r[14] !== 1'b0; i++) br(8'h20);
    chk(r, 32'h0000_8000);
    br(8'h24);
    chk(r, 32'h0000_0000);
    br(8'h00);
    chk(r, 32'h0000_0001);
  endtask
  task automatic t_lock_por();
    bw(8'h20, 32'h0000_0000);
    bw(8'h20, 32'h0000_8001);
    br(8'h20);
    chk(r, 32'h0000_0000);
    @(posedge clk_i);
    por_i <= 1'b1;
    #1 chk(oe_n, 22'h3F_FFFF);
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_disabled();
    t_enable();
    t_dma();
    t_irq();
    t_soft();
    t_lock_por();
    tally_and_finish();
  end
endmodule
